// file: rtcf_regs.vh
`ifndef RTCF_REGS_VH
`define RTCF_REGS_VH

`define RTCF_ADDR_SEC       4'h0
`define RTCF_ADDR_MIN       4'h1
`define RTCF_ADDR_HOUR      4'h2
`define RTCF_ADDR_WDAY      4'h3
`define RTCF_ADDR_MDAY      4'h4
`define RTCF_ADDR_MONTH     4'h5
`define RTCF_ADDR_YEAR      4'h6
`define RTCF_ADDR_CTRL_ONE  4'he
`define RTCF_ADDR_CTRL_TWO  4'hf

`define RTCF_MASK_SEC       8'h7f
`define RTCF_MASK_HOUR      8'h3f
`define RTCF_MASK_WDAY      8'h07
`define RTCF_MASK_MDAY      8'h3f
`define RTCF_MASK_MONTH     8'h9f

`define RTCF_C1_WEEKLY_ALARM_ENABLE        7
`define RTCF_C1_DAILY_ALARM_ENABLE        6
`define RTCF_C1_H24         5
`define RTCF_C1_CLKDIS_B    4
`define RTCF_C2_CLKDIS_A    3
`define RTCF_C2_PERIODIC_IRQ_FLAG        2
`define RTCF_C2_WEEKLY_ALARM_FLAG        1
`define RTCF_C2_DAILY_ALARM_FLAG        0
`define RTCF_HOUR_PM        5
`define RTCF_MONTH_CENT     7

`define RTCF_BCD_00         8'h00
`define RTCF_BCD_01         8'h01
`define RTCF_BCD_11         8'h11
`define RTCF_BCD_12         8'h12
`define RTCF_BCD_23         8'h23
`define RTCF_BCD_28         8'h28
`define RTCF_BCD_29         8'h29
`define RTCF_BCD_30         8'h30
`define RTCF_BCD_31         8'h31
`define RTCF_BCD_32         8'h32
`define RTCF_BCD_59         8'h59
`define RTCF_BCD_99         8'h99
`define RTCF_WDAY_LAST      3'h6
`define RTCF_FEB            5'h02

`define RTCF_CT_OFF         3'h0
`define RTCF_CT_LOW         3'h1
`define RTCF_CT_2HZ         3'h2
`define RTCF_CT_1HZ         3'h3
`define RTCF_CT_SEC         3'h4
`define RTCF_CT_MIN         3'h5
`define RTCF_CT_HOUR        3'h6
`define RTCF_CT_MONTH       3'h7

`define RTCF_PRESC_W        15
`define RTCF_CLK_NS         10
`define RTCF_ALM_DLY_NS     31000
`define RTCF_ALM_DLY_CYC    ((`RTCF_ALM_DLY_NS + `RTCF_CLK_NS - 1) / `RTCF_CLK_NS)
`define RTCF_ALM_CNT_W      12

`endif

// file: rtcf_core.v
`timescale 1ns/1ps
`include "rtcf_regs.vh"

module rtcf_core #(
  parameter PRESC_W = `RTCF_PRESC_W
) (
  input  wire       i_mclk,
  input  wire       i_arst_n,
  input  wire       i_ce,
  input  wire       i_osc_tick,
  input  wire       i_osc_level,
  input  wire [3:0] i_reg_addr,
  input  wire       i_reg_we,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_weekly_alarm_match,
  input  wire       i_daily_alarm_match,
  output reg  [7:0] o_reg_rdata,
  output reg        o_irq_out_n,
  output reg        o_slow_clock_out_pin
);

  // Increments a two-digit BCD value.
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // Last day of the month in BCD; every year divisible by four leaps.
  function [7:0] month_last;
    input [4:0] mon;
    input [7:0] yr;
    reg         leap;
    begin
      leap = (yr[4] ? (yr[1:0] == 2'h2) : (yr[1:0] == 2'h0));
      case (mon)
        5'h02:   month_last = leap ? `RTCF_BCD_29 : `RTCF_BCD_28;
        5'h04,
        5'h06,
        5'h09,
        5'h11:   month_last = `RTCF_BCD_30;
        default: month_last = `RTCF_BCD_31;
      endcase
    end
  endfunction

  reg [PRESC_W-1:0]        presc;
  reg [7:0]                sec;
  reg [7:0]                min;
  reg [7:0]                hour;
  reg [2:0]                wday;
  reg [7:0]                mday;
  reg [4:0]                month;
  reg                      century;
  reg [7:0]                year;
  reg [2:0]                ct_sel;
  reg                      weekly_alarm_enable;
  reg                      daily_alarm_enable;
  reg                      h24;
  reg                      clkdis_a;
  reg                      clkdis_b;
  reg                      periodic_irq_flag;
  reg                      weekly_alarm_flag;
  reg                      daily_alarm_flag;
  reg [`RTCF_ALM_CNT_W-1:0] wdly;
  reg [`RTCF_ALM_CNT_W-1:0] ddly;

  wire sec_tick   = i_osc_tick && (&presc);
  wire sec_wrap   = sec_tick && (sec == `RTCF_BCD_59);
  wire min_wrap   = sec_wrap && (min == `RTCF_BCD_59);
  wire hour_wrap  = min_wrap && (h24 ? (hour == `RTCF_BCD_23) : (hour == `RTCF_BCD_31));
  wire mday_wrap  = hour_wrap && (mday == month_last(month, year));
  wire month_wrap = mday_wrap && ({3'h0, month} == `RTCF_BCD_12);
  wire year_wrap  = month_wrap && (year == `RTCF_BCD_99);
  wire wr_c1      = i_reg_we && (i_reg_addr == `RTCF_ADDR_CTRL_ONE);
  wire wr_c2      = i_reg_we && (i_reg_addr == `RTCF_ADDR_CTRL_TWO);
  wire level_mode = ct_sel[2];
  wire weekly_alarm_flag_vis   = weekly_alarm_flag && weekly_alarm_enable;
  wire daily_alarm_flag_vis   = daily_alarm_flag && daily_alarm_enable;

  // Incremented month and twelve-hour digits, cut to their field widths where used.
  wire [7:0] month_inc = bcd_inc({3'h0, month});
  wire [7:0] hour_inc  = bcd_inc({3'h0, hour[4:0]});

  // Alarm delay in clock cycles, narrowed to the countdown width where loaded.
  localparam integer ALM_DLY_I = `RTCF_ALM_DLY_CYC;
  wire [31:0] alm_dly_w = ALM_DLY_I;

  reg [7:0] next_hour;
  reg       period_evt;
  reg       pulse_low;

  always @* begin
    next_hour = bcd_inc(hour);
    if (h24) begin
      if (hour == `RTCF_BCD_23) begin
        next_hour = `RTCF_BCD_00;
      end
    end else if (hour == `RTCF_BCD_31) begin
      next_hour = `RTCF_BCD_12;
    end else if (hour[4:0] == `RTCF_BCD_11) begin
      next_hour = `RTCF_BCD_32;
    end else if (hour[4:0] == `RTCF_BCD_12) begin
      next_hour = {2'h0, hour[`RTCF_HOUR_PM], 5'h01};
    end else begin
      next_hour = {2'h0, hour[`RTCF_HOUR_PM], hour_inc[4:0]};
    end
  end

  always @* begin
    pulse_low  = 1'b0;
    period_evt = 1'b0;
    case (ct_sel)
      `RTCF_CT_OFF:   pulse_low = 1'b0;
      `RTCF_CT_LOW:   pulse_low = 1'b1;
      `RTCF_CT_2HZ:   pulse_low = ~presc[PRESC_W-2];
      `RTCF_CT_1HZ:   pulse_low = ~presc[PRESC_W-1];
      `RTCF_CT_SEC:   period_evt = sec_tick;
      `RTCF_CT_MIN:   period_evt = sec_wrap;
      `RTCF_CT_HOUR:  period_evt = min_wrap;
      `RTCF_CT_MONTH: period_evt = mday_wrap;
      default:        pulse_low = 1'b0;
    endcase
  end

  // Time and calendar chain; a host write to a counter wins over its carry.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc   <= {PRESC_W{1'b0}};
      sec     <= `RTCF_BCD_00;
      min     <= `RTCF_BCD_00;
      hour    <= `RTCF_BCD_00;
      wday    <= 3'h0;
      mday    <= `RTCF_BCD_01;
      month   <= 5'h01;
      century <= 1'b0;
      year    <= `RTCF_BCD_00;
    end else if (i_ce) begin
      if (i_reg_we && (i_reg_addr == `RTCF_ADDR_SEC)) begin
        presc <= {PRESC_W{1'b0}};
      end else if (i_osc_tick) begin
        presc <= presc + {{(PRESC_W-1){1'b0}}, 1'b1};
      end
      if (sec_tick) begin
        sec <= sec_wrap ? `RTCF_BCD_00 : bcd_inc(sec);
      end
      if (sec_wrap) begin
        min <= min_wrap ? `RTCF_BCD_00 : bcd_inc(min);
      end
      if (min_wrap) begin
        hour <= next_hour;
      end
      if (hour_wrap) begin
        wday <= (wday == `RTCF_WDAY_LAST) ? 3'h0 : wday + 3'h1;
        mday <= mday_wrap ? `RTCF_BCD_01 : bcd_inc(mday);
      end
      if (mday_wrap) begin
        month <= month_wrap ? 5'h01 : month_inc[4:0];
      end
      if (month_wrap) begin
        year <= year_wrap ? `RTCF_BCD_00 : bcd_inc(year);
      end
      if (year_wrap) begin
        century <= ~century;
      end
      if (i_reg_we) begin
        case (i_reg_addr)
          `RTCF_ADDR_SEC:   sec  <= i_reg_wdata & `RTCF_MASK_SEC;
          `RTCF_ADDR_MIN:   min  <= i_reg_wdata & `RTCF_MASK_SEC;
          `RTCF_ADDR_HOUR:  hour <= i_reg_wdata & `RTCF_MASK_HOUR;
          `RTCF_ADDR_WDAY:  wday <= i_reg_wdata[2:0];
          `RTCF_ADDR_MDAY:  mday <= i_reg_wdata & `RTCF_MASK_MDAY;
          `RTCF_ADDR_MONTH: begin
            month   <= i_reg_wdata[4:0];
            century <= i_reg_wdata[`RTCF_MONTH_CENT];
          end
          `RTCF_ADDR_YEAR:  year <= i_reg_wdata;
          default:          year <= year;
        endcase
      end
    end
  end

  // Control bits, flags, alarm delay and the two pins.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ct_sel               <= `RTCF_CT_OFF;
      weekly_alarm_enable                 <= 1'b0;
      daily_alarm_enable                 <= 1'b0;
      h24                  <= 1'b0;
      clkdis_a             <= 1'b0;
      clkdis_b             <= 1'b0;
      periodic_irq_flag                 <= 1'b0;
      weekly_alarm_flag                 <= 1'b0;
      daily_alarm_flag                 <= 1'b0;
      wdly                 <= {`RTCF_ALM_CNT_W{1'b0}};
      ddly                 <= {`RTCF_ALM_CNT_W{1'b0}};
      o_reg_rdata          <= 8'h00;
      o_irq_out_n          <= 1'b1;
      o_slow_clock_out_pin <= 1'b1;
    end else if (i_ce) begin
      if (wr_c1) begin
        weekly_alarm_enable     <= i_reg_wdata[`RTCF_C1_WEEKLY_ALARM_ENABLE];
        daily_alarm_enable     <= i_reg_wdata[`RTCF_C1_DAILY_ALARM_ENABLE];
        h24      <= i_reg_wdata[`RTCF_C1_H24];
        clkdis_b <= i_reg_wdata[`RTCF_C1_CLKDIS_B];
        ct_sel   <= i_reg_wdata[2:0];
      end
      if (wr_c2) begin
        clkdis_a <= i_reg_wdata[`RTCF_C2_CLKDIS_A];
      end
      if (!level_mode) begin
        periodic_irq_flag <= pulse_low;
      end else if (period_evt) begin
        periodic_irq_flag <= 1'b1;
      end else if (wr_c2 && !i_reg_wdata[`RTCF_C2_PERIODIC_IRQ_FLAG]) begin
        periodic_irq_flag <= 1'b0;
      end
      if (i_weekly_alarm_match) begin
        wdly <= alm_dly_w[`RTCF_ALM_CNT_W-1:0];
      end else if (wdly != {`RTCF_ALM_CNT_W{1'b0}}) begin
        wdly <= wdly - {{(`RTCF_ALM_CNT_W-1){1'b0}}, 1'b1};
      end
      if (i_daily_alarm_match) begin
        ddly <= alm_dly_w[`RTCF_ALM_CNT_W-1:0];
      end else if (ddly != {`RTCF_ALM_CNT_W{1'b0}}) begin
        ddly <= ddly - {{(`RTCF_ALM_CNT_W-1){1'b0}}, 1'b1};
      end
      if (!weekly_alarm_enable) begin
        weekly_alarm_flag <= 1'b0;
      end else if (wdly == {{(`RTCF_ALM_CNT_W-1){1'b0}}, 1'b1}) begin
        weekly_alarm_flag <= 1'b1;
      end else if (wr_c2 && !i_reg_wdata[`RTCF_C2_WEEKLY_ALARM_FLAG]) begin
        weekly_alarm_flag <= 1'b0;
      end
      if (!daily_alarm_enable) begin
        daily_alarm_flag <= 1'b0;
      end else if (ddly == {{(`RTCF_ALM_CNT_W-1){1'b0}}, 1'b1}) begin
        daily_alarm_flag <= 1'b1;
      end else if (wr_c2 && !i_reg_wdata[`RTCF_C2_DAILY_ALARM_FLAG]) begin
        daily_alarm_flag <= 1'b0;
      end
      o_irq_out_n          <= ~(periodic_irq_flag | weekly_alarm_flag_vis | daily_alarm_flag_vis);
      o_slow_clock_out_pin <= (clkdis_a && clkdis_b) ? 1'b1 : i_osc_level;
      case (i_reg_addr)
        `RTCF_ADDR_SEC:      o_reg_rdata <= sec;
        `RTCF_ADDR_MIN:      o_reg_rdata <= min;
        `RTCF_ADDR_HOUR:     o_reg_rdata <= hour;
        `RTCF_ADDR_WDAY:     o_reg_rdata <= {5'h00, wday};
        `RTCF_ADDR_MDAY:     o_reg_rdata <= mday;
        `RTCF_ADDR_MONTH:    o_reg_rdata <= {century, 2'h0, month};
        `RTCF_ADDR_YEAR:     o_reg_rdata <= year;
        `RTCF_ADDR_CTRL_ONE: o_reg_rdata <= {weekly_alarm_enable, daily_alarm_enable, h24, clkdis_b, 1'b0, ct_sel};
        `RTCF_ADDR_CTRL_TWO: o_reg_rdata <= {4'h0, clkdis_a, periodic_irq_flag, weekly_alarm_flag_vis, daily_alarm_flag_vis};
        default:             o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// file: rtcf_osc_model.sv
`timescale 1ns/1ps
// Free-running crystal stand-in: one tick and one level period every four clocks.
module rtcf_osc_model (
  input  wire i_mclk,
  output reg  o_osc_tick,
  output reg  o_osc_level
);
  reg [1:0] div = 2'h0;
  initial begin
    o_osc_tick = 1'b0;
    o_osc_level = 1'b0;
  end
  always @(negedge i_mclk) begin
    div <= div + 2'h1;
    o_osc_tick <= (div == 2'h3);
    o_osc_level <= div[1];
  end
endmodule

// file: rtcf_core_assertions.sv
`timescale 1ns/1ps
module rtcf_chk (
  input wire       i_mclk,
  input wire       i_arst_n,
  input wire       i_ce,
  input wire       i_osc_tick,
  input wire       i_osc_level,
  input wire [3:0] i_reg_addr,
  input wire       i_reg_we,
  input wire [7:0] i_reg_wdata,
  input wire       i_weekly_alarm_match,
  input wire       i_daily_alarm_match,
  input wire [7:0] o_reg_rdata,
  input wire       o_irq_out_n,
  input wire       o_slow_clock_out_pin
);
  reg [7:0]  c1;
  reg        dis_a;
  reg [11:0] acnt;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Shadows of the control bits and a countdown to the alarm pin fall.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      c1 <= 8'h00;
      dis_a <= 1'b0;
      acnt <= 12'h000;
    end else if (i_ce) begin
      if (i_reg_we && i_reg_addr == 4'he) begin
        c1 <= i_reg_wdata;
      end
      if (i_reg_we && i_reg_addr == 4'hf) begin
        dis_a <= i_reg_wdata[3];
      end
      if ((i_weekly_alarm_match && c1[7]) || (i_daily_alarm_match && c1[6])) begin
        acnt <= 12'hc1d;
      end else if (acnt != 12'h000) begin
        acnt <= acnt - 12'h001;
      end
    end
  end
  a_clkout_off: assert property (c1[4] && dis_a |=> o_slow_clock_out_pin)
    else $error("clock out not held high");
  a_clkout_run: assert property (!(c1[4] && dis_a) |=> o_slow_clock_out_pin == $past(i_osc_level))
    else $error("clock out not following oscillator");
  a_flag_pin: assert property ($past(i_reg_addr) == 4'hf |-> o_irq_out_n == (o_reg_rdata[2:0] == 3'h0))
    else $error("flags and interrupt pin disagree");
  a_alarm_delay: assert property (acnt == 12'h001 |=> !o_irq_out_n)
    else $error("alarm interrupt late");
  a_unmapped_zero: assert property (i_reg_addr > 4'h6 && i_reg_addr < 4'he |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sec_bcd: assert property (i_reg_addr == 4'h0 |=> o_reg_rdata[7] == 1'b0 && o_reg_rdata[6:4] < 3'h6 && o_reg_rdata[3:0] < 4'ha)
    else $error("seconds out of range");
  a_wday_range: assert property (i_reg_addr == 4'h3 |=> o_reg_rdata < 8'h07)
    else $error("weekday out of range");
  a_month_bits: assert property (i_reg_addr == 4'h5 |=> o_reg_rdata[6:5] == 2'h0 && o_reg_rdata[4:0] != 5'h00)
    else $error("month read malformed");
  a_hour_bits: assert property (i_reg_addr == 4'h2 |=> o_reg_rdata[7:6] == 2'h0)
    else $error("hour upper bits set");
  c_alarm: cover property (acnt == 12'h001);
  c_clk_off: cover property (c1[4] && dis_a && o_slow_clock_out_pin);
  c_flag: cover property ($past(i_reg_addr) == 4'hf && o_reg_rdata[2]);
endmodule

// file: rtcf_core_test.sv
`timescale 1ns/1ps
module rtcf_core_test;
  reg        i_mclk = 1'b0;
  reg        i_arst_n = 1'b0;
  reg  [3:0] i_reg_addr = 4'h0;
  reg        i_reg_we = 1'b0;
  reg  [7:0] i_reg_wdata = 8'h00;
  reg        wk = 1'b0;
  reg        dy = 1'b0;
  wire       tick;
  wire       lvl;
  wire [7:0] rdata;
  wire       irq_n;
  wire       clk_out;
  integer    num_errors = 0;
  integer    compares = 0;
  integer    cyc = 0;
  integer    i;
  integer    n;
  reg [87:0] t [0:7];
  always #5 i_mclk = ~i_mclk;
  rtcf_osc_model u_rtcf_osc_model (.i_mclk(i_mclk), .o_osc_tick(tick), .o_osc_level(lvl));
  rtcf_core #(.PRESC_W(4)) u_rtcf_core (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(1'b1),
    .i_osc_tick(tick), .i_osc_level(lvl), .i_reg_addr(i_reg_addr), .i_reg_we(i_reg_we),
    .i_reg_wdata(i_reg_wdata), .i_weekly_alarm_match(wk), .i_daily_alarm_match(dy),
    .o_reg_rdata(rdata), .o_irq_out_n(irq_n), .o_slow_clock_out_pin(clk_out));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (num_errors == 0 && compares > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge i_mclk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_we = 1'b1;
      @(negedge i_mclk);
      i_reg_we = 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(negedge i_mclk);
      i_reg_addr = a;
      @(negedge i_mclk);
      check(rdata, e);
    end
  endtask
  task pulse(input w);
    begin
      @(negedge i_mclk);
      wk = w;
      dy = !w;
      @(negedge i_mclk);
      wk = 1'b0;
      dy = 1'b0;
    end
  endtask
  task wait_low;
    begin
      n = 0;
      repeat (2) @(negedge i_mclk);
      while (irq_n !== 1'b0 && n < 80) begin
        @(negedge i_mclk);
        n = n + 1;
      end
      check({7'h0, irq_n}, 8'h00);
    end
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  initial begin
    t[0] = 88'h20_23_06_28_02_00_00_00_29_02_00;
    t[1] = 88'h20_23_02_29_02_00_00_03_01_03_00;
    t[2] = 88'h20_23_00_28_02_01_00_01_01_03_01;
    t[3] = 88'h20_23_01_30_04_96_00_02_01_05_96;
    t[4] = 88'h20_23_05_31_12_99_00_06_01_81_00;
    t[5] = 88'h00_31_03_31_01_05_12_04_01_02_05;
    t[6] = 88'h00_11_03_15_06_07_32_03_15_06_07;
    t[7] = 88'h00_29_02_10_07_08_30_02_10_07_08;
    repeat (10) @(negedge i_mclk);
    i_arst_n = 1'b1;
    for (i = 3; i < 16; i = i + 1) begin
      rd(i[3:0], (i == 4 || i == 5) ? 8'h01 : 8'h00);
    end
    wr(4'he, 8'h10);
    wr(4'hf, 8'h08);
    repeat (12) begin
      @(negedge i_mclk);
      check({7'h0, clk_out}, 8'h01);
    end
    wr(4'hf, 8'h00);
    n = 0;
    repeat (12) begin
      @(negedge i_mclk);
      n = n + clk_out;
    end
    check(n[7:0], 8'h06);
    wr(4'h0, 8'h10);
    repeat (50) @(negedge i_mclk);
    wr(4'h0, 8'h20);
    repeat (50) @(negedge i_mclk);
    rd(4'h0, 8'h20);
    repeat (20) @(negedge i_mclk);
    rd(4'h0, 8'h21);
    for (i = 0; i < 8; i = i + 1) begin
      wr(4'he, t[i][87:80]);
      wr(4'h1, 8'h59);
      wr(4'h2, t[i][79:72]);
      wr(4'h3, t[i][71:64]);
      wr(4'h4, t[i][63:56]);
      wr(4'h5, t[i][55:48]);
      wr(4'h6, t[i][47:40]);
      wr(4'h0, 8'h59);
      repeat (66) @(negedge i_mclk);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h2, t[i][39:32]);
      rd(4'h3, t[i][31:24]);
      rd(4'h4, t[i][23:16]);
      rd(4'h5, t[i][15:8]);
      rd(4'h6, t[i][7:0]);
    end
    wr(4'he, 8'h21);
    repeat (3) @(negedge i_mclk);
    rd(4'hf, 8'h04);
    wr(4'he, 8'h24);
    wr(4'hf, 8'h00);
    wait_low;
    wr(4'hf, 8'h04);
    rd(4'hf, 8'h04);
    wr(4'hf, 8'h00);
    rd(4'hf, 8'h00);
    check({7'h0, irq_n}, 8'h01);
    wait_low;
    wr(4'hf, 8'h00);
    wr(4'he, 8'ha0);
    pulse(1'b1);
    n = 0;
    while (irq_n !== 1'b0 && n < 3200) begin
      @(negedge i_mclk);
      n = n + 1;
    end
    check(n[11:4], 8'hc1);
    check({4'h0, n[3:0]}, 8'h0d);
    rd(4'hf, 8'h02);
    wr(4'hf, 8'h02);
    rd(4'hf, 8'h02);
    wr(4'hf, 8'h00);
    rd(4'hf, 8'h00);
    check({7'h0, irq_n}, 8'h01);
    wr(4'he, 8'h20);
    pulse(1'b0);
    repeat (3200) @(negedge i_mclk);
    rd(4'hf, 8'h00);
    wr(4'he, 8'h60);
    pulse(1'b0);
    repeat (3200) @(negedge i_mclk);
    rd(4'hf, 8'h01);
    wr(4'he, 8'h20);
    rd(4'hf, 8'h00);
    check({7'h0, irq_n}, 8'h01);
    wr(4'he, 8'h03);
    repeat (2) @(negedge i_mclk);
    n = 0;
    repeat (64) begin
      @(negedge i_mclk);
      n = n + !irq_n;
    end
    check(n[7:0], 8'h20);
    wr(4'he, 8'h02);
    repeat (2) @(negedge i_mclk);
    n = 0;
    repeat (32) begin
      @(negedge i_mclk);
      n = n + !irq_n;
    end
    check(n[7:0], 8'h10);
    results;
  end
endmodule
bind rtcf_core rtcf_chk u_rtcf_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce),
  .i_osc_tick(i_osc_tick), .i_osc_level(i_osc_level), .i_reg_addr(i_reg_addr),
  .i_reg_we(i_reg_we), .i_reg_wdata(i_reg_wdata), .i_weekly_alarm_match(i_weekly_alarm_match),
  .i_daily_alarm_match(i_daily_alarm_match), .o_reg_rdata(o_reg_rdata),
  .o_irq_out_n(o_irq_out_n), .o_slow_clock_out_pin(o_slow_clock_out_pin));
